/* File: hdl/pgts_pkg.sv */
// Package for the power-good, thermal and stack sequencer.
// Assumes a 200 MHz core clock; all timing derives from it here.
package pgts_pkg;
  // Clock rate and deglitch time
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PG_DEGLITCH_US = 40;
  localparam int unsigned PG_DEGLITCH_CYC = PG_DEGLITCH_US * CLK_MHZ;
  // Initialization time before the role strap is taken
  localparam int unsigned INIT_US = 400;
  localparam int unsigned INIT_CYC = INIT_US * CLK_MHZ;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] CTRL1_ADDR = 8'h04;
  localparam logic [7:0] CTRL3_ADDR = 8'h08;
  localparam logic [7:0] ROLE_ADDR = 8'h0C;
  // Field positions
  localparam int unsigned ST_THERMAL_WARNING_FLAG_BIT = 0;
  localparam int unsigned ST_THERMAL_SHUTDOWN_FLAG_BIT = 1;
  localparam int unsigned C1_DISCH_BIT = 0;
  localparam int unsigned C1_FPWM_BIT = 1;
  localparam int unsigned C3_PGBLNK_BIT = 0;
  localparam int unsigned C3_NOENPD_BIT = 1;
  // Reset values
  localparam logic [1:0] CTRL1_RST = 2'h1;
  localparam logic [1:0] CTRL3_RST = 2'h0;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_OFF = 3'b001,
    ST_SOFT = 3'b010,
    ST_RUN = 3'b011,
    ST_HOT = 3'b100
  } pgts_state_t;
endpackage

/* File: hdl/pgts_seq.sv */
// Supervisory sequencer: power good, thermal flags, stack start-up.
// Assumes analog comparators and pins arrive asynchronously; pins are
// open drain, split into input, output and output enable (low = drive).
//
// Function
// - Power good low in shutdown, off, lockout, soft-start
// - Window fault outside 95 to 105 percent
// - Forty microsecond deglitch before power good pin
// - Blanking ignores window during voltage ramp
// - Warning temperature sets sticky warning flag
// - Status read clears warning below release
// - Shutdown temperature stops switching, flags, pulls good
// - Enable pulldown on shutdown unless disabled
// - Discharge on shutdown when enabled
// - Cooling restarts soft-start, releases enable, good
// - Status read clears shutdown flag below release
// - Role strap sensed once at initialization
// - Secondary presets both latches at initialization
// - Secondary soft-start done clears pulldown latch
// - Power good rise clears conduction hold latch
// - Each device holds ready line during start/fault
// - Primary holds compensation low until ready
// - Secondaries release good; primary drives it
// - Clock daisy-chained, neighbours phase shifted
// - Secondaries force PWM; primary configured so
// - Shutdown or lockout disables whole stack
// - Secondary takes clock on mode input
`timescale 1ns/1ps
`default_nettype none
module pgts_seq #(
  parameter int unsigned DEGLITCH_CYC = pgts_pkg::PG_DEGLITCH_CYC,
  parameter int unsigned INIT_CYC = pgts_pkg::INIT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Analog status inputs (asynchronous)
  input wire logic vout_below_95,
  input wire logic vout_above_105,
  input wire logic temp_above_150,
  input wire logic temp_above_130,
  input wire logic temp_above_170,
  input wire logic undervoltage_lockout_active,
  input wire logic voltage_ramp_active,
  input wire logic soft_start_done,
  input wire logic switch_enable,
  // Open-drain pins: enable / stack ready line
  input wire logic stack_ready_in,
  output logic stack_ready_out,
  output logic stack_ready_oe_n,
  // Open-drain power_good_line
  input wire logic pg_in,
  output logic pg_out,
  output logic pg_oe_n,
  // Role strap and clock chain
  input wire logic clock_chain_strap,
  input wire logic mode_clock_in,
  output logic mode_is_clock,
  // Converter control
  output logic switching_on,
  output logic soft_start_go,
  output logic discharge_on,
  output logic forced_pwm,
  output logic ccm_enable,
  output logic comp_clamp,
  output logic is_secondary
);
  localparam int CW = $clog2(INIT_CYC + 1);
  localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYC - 1);
  localparam int DW = $clog2(DEGLITCH_CYC + 1);
  localparam logic [DW-1:0] DG_LAST = DW'(DEGLITCH_CYC - 1);

  // Two-flop synchronisers for every asynchronous input
  localparam int NS = 12;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  assign raw_in = {mode_clock_in, clock_chain_strap, pg_in, stack_ready_in,
    switch_enable, soft_start_done, voltage_ramp_active, undervoltage_lockout_active,
    temp_above_170, temp_above_130, temp_above_150,
    vout_below_95 | vout_above_105};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  logic win_fault, t150, t130, t170, undervoltage_lockout, ramp, ss_done, sw_en;
  logic ready_s, pg_s, strap_s;
  assign win_fault = sync2[0];
  assign t150 = sync2[1];
  assign t130 = sync2[2];
  assign t170 = sync2[3];
  assign undervoltage_lockout = sync2[4];
  assign ramp = sync2[5];
  assign ss_done = sync2[6];
  assign sw_en = sync2[7];
  assign ready_s = sync2[8];
  assign pg_s = sync2[9];
  assign strap_s = sync2[10];

  // Software registers
  logic [1:0] ctrl1;
  logic [1:0] ctrl3;
  logic thermal_warning_flag_flag;
  logic thermal_shutdown_flag_flag;
  logic status_rd;
  assign status_rd = reg_rd && (reg_addr == pgts_pkg::STATUS_ADDR);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1 <= pgts_pkg::CTRL1_RST;
      ctrl3 <= pgts_pkg::CTRL3_RST;
    end else if (reg_wr) begin
      if (reg_addr == pgts_pkg::CTRL1_ADDR) begin
        ctrl1 <= reg_wdata[1:0];
      end
      if (reg_addr == pgts_pkg::CTRL3_ADDR) begin
        ctrl3 <= reg_wdata[1:0];
      end
    end
  end

  // Thermal warning: set wins over a read-clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      thermal_warning_flag_flag <= 1'b0;
    end else if (t150) begin
      thermal_warning_flag_flag <= 1'b1;
    end else if (status_rd && !t130) begin
      thermal_warning_flag_flag <= 1'b0;
    end
  end

  // Thermal shutdown flag: held while still above release threshold
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      thermal_shutdown_flag_flag <= 1'b0;
    end else if (t170) begin
      thermal_shutdown_flag_flag <= 1'b1;
    end else if (status_rd && !t150) begin
      thermal_shutdown_flag_flag <= 1'b0;
    end
  end

  // Hysteretic shutdown condition: enter above 170, leave below 150
  logic hot;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hot <= 1'b0;
    end else if (t170) begin
      hot <= 1'b1;
    end else if (!t150) begin
      hot <= 1'b0;
    end
  end

  // Sequencer; the role strap is caught once, as init ends
  pgts_pkg::pgts_state_t state;
  logic [CW-1:0] init_cnt;
  logic secondary;
  logic ss_done_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= pgts_pkg::ST_INIT;
      init_cnt <= '0;
      secondary <= 1'b0;
    end else begin
      unique case (state)
        pgts_pkg::ST_INIT: begin
          if (init_cnt == INIT_LAST) begin
            secondary <= ~strap_s;
            state <= pgts_pkg::ST_OFF;
          end else begin
            init_cnt <= init_cnt + CW'(1);
          end
        end
        pgts_pkg::ST_OFF: begin
          if (hot) begin
            state <= pgts_pkg::ST_HOT;
          end else if (sw_en && !undervoltage_lockout && ready_s) begin
            state <= pgts_pkg::ST_SOFT;
          end
        end
        pgts_pkg::ST_SOFT: begin
          if (hot) begin
            state <= pgts_pkg::ST_HOT;
          end else if (undervoltage_lockout || !sw_en || !ready_s) begin
            state <= pgts_pkg::ST_OFF;
          end else if (ss_done) begin
            state <= pgts_pkg::ST_RUN;
          end
        end
        pgts_pkg::ST_RUN: begin
          if (hot) begin
            state <= pgts_pkg::ST_HOT;
          end else if (undervoltage_lockout || !sw_en || !ready_s) begin
            state <= pgts_pkg::ST_OFF;
          end
        end
        pgts_pkg::ST_HOT: begin
          if (!hot) begin
            state <= pgts_pkg::ST_OFF;
          end
        end
        default: begin
          state <= pgts_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Deglitch: level must hold DEGLITCH_CYC cycles before it counts
  logic dg_raw;
  logic dg_fault;
  logic [DW-1:0] dg_cnt;
  assign dg_raw = win_fault && !(ctrl3[pgts_pkg::C3_PGBLNK_BIT] && ramp);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dg_cnt <= '0;
      dg_fault <= 1'b1;
    end else if (dg_raw == dg_fault) begin
      dg_cnt <= '0;
    end else if (dg_cnt == DG_LAST) begin
      dg_cnt <= '0;
      dg_fault <= dg_raw;
    end else begin
      dg_cnt <= dg_cnt + DW'(1);
    end
  end

  // Secondary latches: preset at init, cleared by own done / pg rise
  logic pg_pd_latch;
  logic ccm_hold_latch;
  logic pg_s_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pg_pd_latch <= 1'b1;
      ccm_hold_latch <= 1'b1;
      pg_s_q <= 1'b0;
      ss_done_q <= 1'b0;
    end else begin
      pg_s_q <= pg_s;
      ss_done_q <= ss_done;
      if (state == pgts_pkg::ST_INIT) begin
        pg_pd_latch <= 1'b1;
        ccm_hold_latch <= 1'b1;
      end else if (secondary) begin
        if (ss_done && !ss_done_q && state == pgts_pkg::ST_SOFT) begin
          pg_pd_latch <= 1'b0;
        end
        if (pg_s && !pg_s_q) begin
          ccm_hold_latch <= 1'b0;
        end
      end
    end
  end

  // Pin and control outputs, all registered
  logic pg_low;
  logic in_fault;
  assign in_fault = hot || undervoltage_lockout;
  always_comb begin
    if (state == pgts_pkg::ST_INIT) begin
      pg_low = 1'b1;
    end else if (secondary) begin
      pg_low = pg_pd_latch;
    end else begin
      pg_low = (state != pgts_pkg::ST_RUN) || dg_fault;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pg_out <= 1'b0;
      pg_oe_n <= 1'b0;
      stack_ready_out <= 1'b0;
      stack_ready_oe_n <= 1'b0;
      comp_clamp <= 1'b1;
      switching_on <= 1'b0;
      soft_start_go <= 1'b0;
      discharge_on <= 1'b0;
      forced_pwm <= 1'b0;
      ccm_enable <= 1'b0;
      is_secondary <= 1'b0;
      mode_is_clock <= 1'b0;
    end else begin
      pg_out <= 1'b0;
      pg_oe_n <= ~pg_low;
      stack_ready_out <= 1'b0;
      // Pull the ready line while initializing, in lockout, or hot unless C3_NOENPD_BIT is set
      stack_ready_oe_n <= ~((state == pgts_pkg::ST_INIT) || undervoltage_lockout ||
        (hot && !ctrl3[pgts_pkg::C3_NOENPD_BIT]));
      comp_clamp <= !secondary && !ready_s;
      switching_on <= (state == pgts_pkg::ST_SOFT) ||
        (state == pgts_pkg::ST_RUN);
      soft_start_go <= state == pgts_pkg::ST_SOFT;
      // In shutdown or lockout secondaries discharge regardless; primary per control bit
      discharge_on <= (state == pgts_pkg::ST_HOT || in_fault) &&
        (ctrl1[pgts_pkg::C1_DISCH_BIT] || secondary);
      forced_pwm <= secondary || ctrl1[pgts_pkg::C1_FPWM_BIT];
      ccm_enable <= !(secondary && ccm_hold_latch);
      is_secondary <= secondary;
      mode_is_clock <= secondary;
    end
  end

  // Read data: one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pgts_pkg::STATUS_ADDR: reg_rdata <= {30'h0, thermal_shutdown_flag_flag, thermal_warning_flag_flag};
        pgts_pkg::CTRL1_ADDR: reg_rdata <= {30'h0, ctrl1};
        pgts_pkg::CTRL3_ADDR: reg_rdata <= {30'h0, ctrl3};
        pgts_pkg::ROLE_ADDR: reg_rdata <= {29'h0, state};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* File: bench/pgts_peer.sv */
// Peer converter sharing the ready and power-good lines.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module pgts_peer (
  // Clock and commands from the bench
  input wire logic core_clk,
  input wire logic hold_ready,
  input wire logic hold_pg,
  // Open-drain pulls, low = drive
  output logic ready_oe_n,
  output logic pg_oe_n,
  // Chained clock to the next device
  output logic chain_clk
);
  logic [1:0] div = 2'h0;
  // Pull in own start-up or fault; combinational so lines exist at time 0
  assign ready_oe_n = !hold_ready;
  assign pg_oe_n = !hold_pg;
  // Divided clock stands in for the phase-shifted chain output
  always @(posedge core_clk) div <= div + 2'h1;
  assign chain_clk = div[1];
endmodule
`default_nettype wire

/* File: bench/pgts_checker.sv */
// Checker on the pgts_seq ports.
// Assumes the bind below; DEGLITCH_CYC follows the instance.
`timescale 1ns/1ps
`default_nettype none
module pgts_checker #(
  parameter int unsigned DEGLITCH_CYC = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic vout_below_95,
  input wire logic vout_above_105,
  input wire logic temp_above_170,
  input wire logic undervoltage_lockout_active,
  input wire logic voltage_ramp_active,
  input wire logic stack_ready_in,
  input wire logic stack_ready_oe_n,
  input wire logic pg_in,
  input wire logic pg_oe_n,
  input wire logic switching_on,
  input wire logic forced_pwm,
  input wire logic mode_is_clock,
  input wire logic ccm_enable,
  input wire logic comp_clamp,
  input wire logic is_secondary
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  int unsigned ok_cnt, bad_cnt;
  wire logic win_bad = (vout_below_95 | vout_above_105) & !voltage_ramp_active;
  // Run lengths; ramps count as good so blanking never trips these
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ok_cnt <= '0;
      bad_cnt <= '0;
    end else begin
      ok_cnt <= win_bad ? '0 : ok_cnt + 1;
      bad_cnt <= win_bad ? bad_cnt + 1 : '0;
    end
  end
  sequence s_hot;
    temp_above_170 [*6];
  endsequence
  sequence s_pg_rise;
    (is_secondary && !pg_in) ##1 (is_secondary && pg_in) [*6];
  endsequence
  chk_undervoltage_lockout_pulls: assert property (undervoltage_lockout_active [*5]
    |-> !pg_oe_n && !stack_ready_oe_n) else $error("undervoltage_lockout pull missing");
  chk_hot_stop: assert property (s_hot
    |-> !switching_on && !pg_oe_n) else $error("hot but running");
  chk_pg_glitch: assert property ($rose(pg_oe_n) && !is_secondary
    |-> ok_cnt >= DEGLITCH_CYC) else $error("pg released early");
  chk_pg_fault: assert property (!is_secondary
    && bad_cnt > DEGLITCH_CYC + 6 |-> !pg_oe_n) else $error("pg not low");
  chk_clamp_ready: assert property (
    (!is_secondary && !stack_ready_in) [*5] |-> comp_clamp)
    else $error("comp not clamped");
  chk_role_hold: assert property (is_secondary
    |=> is_secondary) else $error("role changed");
  chk_sec_pwm: assert property ($rose(is_secondary)
    |-> ##[0:2] (forced_pwm && mode_is_clock)) else $error("sec mode");
  chk_ccm_edge: assert property (s_pg_rise
    |-> ccm_enable) else $error("ccm not taken");
endmodule
bind pgts_seq pgts_checker #(.DEGLITCH_CYC(DEGLITCH_CYC)) pgts_checker_i (
  .core_clk, .nrst, .vout_below_95, .vout_above_105, .temp_above_170,
  .undervoltage_lockout_active, .voltage_ramp_active, .stack_ready_in, .stack_ready_oe_n,
  .pg_in, .pg_oe_n, .switching_on, .forced_pwm, .mode_is_clock,
  .ccm_enable, .comp_clamp, .is_secondary);
`default_nettype wire

/* File: bench/tb_top.sv */
// Bench for pgts_seq with one peer on the shared lines.
// Assumes short deglitch and init counts chosen here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned INI = 16;
  logic core_clk = 1'b0;
  logic nrst, reg_wr, reg_rd, vout_below_95, vout_above_105;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic temp_above_150, temp_above_130, temp_above_170, undervoltage_lockout_active;
  logic voltage_ramp_active, soft_start_done, switch_enable;
  logic clock_chain_strap, hold_ready, hold_pg, ready_oe_n, peer_pg_n;
  logic stack_ready_in, stack_ready_out, stack_ready_oe_n;
  logic pg_in, pg_out, pg_oe_n, mode_clock_in, mode_is_clock;
  logic switching_on, soft_start_go, discharge_on, forced_pwm;
  logic ccm_enable, comp_clamp, is_secondary;
  int n_errors = 0;
  int compares = 0;
  int n;
  always #2.5 core_clk = ~core_clk;
  // Pulled-up wires: high unless someone drives low
  assign stack_ready_in = stack_ready_oe_n & ready_oe_n;
  assign pg_in = pg_oe_n & peer_pg_n;
  pgts_seq #(.DEGLITCH_CYC(8), .INIT_CYC(INI)) pgts_seq_i (
    .core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .vout_below_95, .vout_above_105, .temp_above_150,
    .temp_above_130, .temp_above_170, .undervoltage_lockout_active, .voltage_ramp_active,
    .soft_start_done, .switch_enable, .stack_ready_in, .stack_ready_out,
    .stack_ready_oe_n, .pg_in, .pg_out, .pg_oe_n, .clock_chain_strap,
    .mode_clock_in, .mode_is_clock, .switching_on, .soft_start_go,
    .discharge_on, .forced_pwm, .ccm_enable, .comp_clamp, .is_secondary);
  pgts_peer pgts_peer_i (.core_clk, .hold_ready, .hold_pg, .ready_oe_n,
    .pg_oe_n(peer_pg_n), .chain_clk(mode_clock_in));
  // Verdict and end of run
  task automatic test_done();
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Cycles; outputs have settled 1 ns after the edge
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded wait on the power-good pull, cycles taken in n
  task automatic wait_pg(input logic v);
    for (n = 0; pg_oe_n !== v; n++) begin
      if (n > 80) begin
        n_errors++;
        test_done();
      end
      tick(1);
    end
  endtask
  // Register port; the idle cycle keeps strobes from retriggering
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    cmp(reg_rdata, e);
    tick(1);
  endtask
  task automatic do_reset(input logic strap);
    nrst <= 1'b0;
    clock_chain_strap <= strap;
    tick(12);
    cmp({pg_oe_n, stack_ready_oe_n, comp_clamp}, 32'h0000_0001);
    nrst <= 1'b1;
    tick(INI + 4);
  endtask
  task automatic t_regs();
    rd(8'h04, 32'h0000_0001);
    rd(8'h08, 32'h0000_0000);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0000);
  endtask
  task automatic t_start();
    cmp(comp_clamp, 32'h0000_0001);
    hold_ready <= 1'b0;
    tick(6);
    cmp({comp_clamp, pg_oe_n}, 32'h0000_0000);
    wr(8'h04, 32'h0000_0003);
    cmp(forced_pwm, 32'h0000_0001);
    soft_start_done <= 1'b1;
    wait_pg(1'b1);
  endtask
  task automatic t_window();
    vout_below_95 <= 1'b1;
    tick(5);
    vout_below_95 <= 1'b0;
    tick(16);
    cmp(pg_oe_n, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      {vout_below_95, vout_above_105} <= k ? 2'h1 : 2'h2;
      wait_pg(1'b0);
      cmp(n >= 8, 32'h0000_0001);
      {vout_below_95, vout_above_105} <= 2'h0;
      wait_pg(1'b1);
      cmp(n >= 8, 32'h0000_0001);
    end
  endtask
  task automatic t_blank();
    wr(8'h08, 32'h0000_0001);
    {voltage_ramp_active, vout_above_105} <= 2'h3;
    tick(20);
    cmp(pg_oe_n, 32'h0000_0001);
    {voltage_ramp_active, vout_above_105} <= 2'h0;
  endtask
  task automatic t_thermal();
    {temp_above_150, temp_above_130} <= 2'h3;
    tick(4);
    rd(8'h00, 32'h0000_0001);
    temp_above_150 <= 1'b0;
    tick(4);
    rd(8'h00, 32'h0000_0001);
    temp_above_130 <= 1'b0;
    tick(4);
    rd(8'h00, 32'h0000_0001);
    rd(8'h00, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      wr(8'h08, k ? 32'h0000_0002 : 32'h0000_0000);
      wr(8'h04, k ? 32'h0000_0002 : 32'h0000_0003);
      {temp_above_150, temp_above_130, temp_above_170} <= 3'h7;
      soft_start_done <= 1'b0;
      tick(5);
      cmp({switching_on, pg_oe_n, stack_ready_oe_n, discharge_on},
        k ? 32'h0000_0002 : 32'h0000_0001);
      rd(8'h00, 32'h0000_0003);
      temp_above_170 <= 1'b0;
      tick(5);
      cmp(switching_on, 32'h0000_0000);
      {temp_above_150, temp_above_130} <= 2'h0;
      // Ready line must resync before the new soft start registers
      tick(10);
      cmp({switching_on, soft_start_go, stack_ready_oe_n},
        32'h0000_0007);
      rd(8'h00, 32'h0000_0003);
      rd(8'h00, 32'h0000_0000);
      soft_start_done <= 1'b1;
      wait_pg(1'b1);
    end
  endtask
  task automatic t_undervoltage_lockout();
    undervoltage_lockout_active <= 1'b1;
    tick(5);
    cmp({pg_oe_n, stack_ready_oe_n}, 32'h0000_0000);
    undervoltage_lockout_active <= 1'b0;
    wait_pg(1'b1);
  endtask
  task automatic t_second();
    {soft_start_done, hold_pg} <= 2'h1;
    do_reset(1'b0);
    cmp({is_secondary, forced_pwm, mode_is_clock, pg_oe_n, ccm_enable},
      32'h0000_001C);
    clock_chain_strap <= 1'b1;
    soft_start_done <= 1'b1;
    wait_pg(1'b1);
    cmp({is_secondary, ccm_enable}, 32'h0000_0002);
    hold_pg <= 1'b0;
    tick(8);
    cmp(ccm_enable, 32'h0000_0001);
  endtask
  // Main sequence; all inputs get a value at time zero
  initial begin
    {reg_wr, reg_rd, vout_below_95, vout_above_105} <= 4'h0;
    {temp_above_150, temp_above_130, temp_above_170} <= 3'h0;
    {undervoltage_lockout_active, voltage_ramp_active, soft_start_done, hold_pg} <= 4'h0;
    {switch_enable, hold_ready} <= 2'h3;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h0000_0000;
    do_reset(1'b1);
    t_regs();
    t_start();
    t_window();
    t_blank();
    t_thermal();
    t_undervoltage_lockout();
    t_second();
    test_done();
  end
endmodule
`default_nettype wire
